/* rasp_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// RL1: Send and receive raw characters, no framing
// RL2: Response timeout after send flags error
// RL3: Raise RTS, wait on-delay, then send
// RL4: Wait off-delay after last char, drop RTS
// RL5: Seven or eight data bits selectable
// RL6: Eight selectable baud rates
// RL7: One or two stop bits
// RL8: None, even, odd parity generated and checked
// RL9: Echo suppression per wiring type
// RL10: XON/XOFF pauses and resumes transmit
// RL11: RTS flow control gates transfers
// RL12: Setup block base address register
// RL13: Print-only mode transmits, never receives
// RL14: Start bit, LSB first, parity, stops
module rasp_top
  import rasp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  output logic serial_transmit_out,
  input wire logic serial_receive_in,
  output logic request_to_send_out,
  input wire logic clear_to_send_in,
  // Interrupt
  output logic irq
);
  import rasp_pkg::*;
  // ==========================================================
  // Registers
  logic [12:0] cfg;
  logic [15:0] tmo_ms;
  logic [15:0] rts_on_ms;
  logic [15:0] rts_off_ms;
  logic [15:0] base_addr;
  logic [RASP_NSTAT-1:0] stat;
  logic [RASP_NSTAT-1:0] ien;
  logic [7:0] rx_hold;
  logic [7:0] tx_hold;
  logic tx_pend;
  logic [15:0] div;
  logic db8;
  logic stop2;
  logic [1:0] par;
  logic [1:0] echo;
  logic print_only;
  always_comb begin
    div = rasp_div(cfg[RASP_CFG_BAUD +: 3]); // RL6
    db8 = cfg[RASP_CFG_DB8]; // RL5
    stop2 = cfg[RASP_CFG_STOP2]; // RL7
    par = cfg[RASP_CFG_PAR +: 2]; // RL8
    echo = cfg[RASP_CFG_ECHO +: 2];
    print_only = cfg[RASP_CFG_PRINT];
  end
  // ==========================================================
  // Pin synchronisers
  logic rx_s1, rx_s2, cts_s1, cts_s2;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
    end else begin
      rx_s1 <= serial_receive_in;
      rx_s2 <= rx_s1;
      cts_s1 <= clear_to_send_in;
      cts_s2 <= cts_s1;
    end
  end
  // ==========================================================
  // APB decode, zero wait states
  logic wr_en, rd_en, mapped;
  always_comb begin
    wr_en = psel && penable && pwrite;
    rd_en = psel && penable && !pwrite;
    mapped = paddr[1:0] == 2'b00 && paddr <= RASP_BASE_OFS;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end
  logic acc;
  assign acc = psel && penable && pready && mapped;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg <= RASP_CFG_RST;
      tmo_ms <= RASP_TMO_RST;
      rts_on_ms <= RASP_RTSD_RST;
      rts_off_ms <= RASP_RTSD_RST;
      base_addr <= RASP_BASE_RST;
      ien <= '0;
    end else if (acc && wr_en) begin
      case (paddr)
        RASP_CFG_OFS: cfg <= pwdata[12:0];
        RASP_TMO_OFS: tmo_ms <= pwdata[15:0];
        RASP_RTS_OFS: begin
          rts_on_ms <= pwdata[15:0];
          rts_off_ms <= pwdata[31:16];
        end
        RASP_BASE_OFS: base_addr <= pwdata[15:0]; // RL12
        RASP_IEN_OFS: ien <= pwdata[RASP_NSTAT-1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        RASP_CFG_OFS: prdata <= {19'h0, cfg};
        RASP_TMO_OFS: prdata <= {16'h0, tmo_ms};
        RASP_RTS_OFS: prdata <= {rts_off_ms, rts_on_ms};
        RASP_RXD_OFS: prdata <= {24'h0, rx_hold}; // RL1
        RASP_STAT_OFS: prdata <= {23'h0, tx_pend, 2'h0, stat};
        RASP_IEN_OFS: prdata <= {26'h0, ien};
        RASP_BASE_OFS: prdata <= {16'h0, base_addr};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // Transmit sequencing with RTS delays
  typedef enum logic [2:0] {
    RASP_IDLE = 3'b000,
    RASP_RTSON = 3'b001,
    RASP_SEND = 3'b010,
    RASP_WAIT = 3'b011,
    RASP_RTSOFF = 3'b100
  } rasp_state_t;
  rasp_state_t state;
  logic [15:0] ms_cnt;
  logic [15:0] ms_left;
  logic ms_tick;
  logic tx_start, tx_busy, tx_done, tx_line;
  logic xoff_seen;
  logic sent_evt;
  logic cts_ok;
  assign ms_tick = ms_cnt == 16'(RASP_MS_CYC - 1);
  // Hardware handshake only when a flow mode wires CTS
  assign cts_ok = !(cfg[RASP_CFG_RTSFC] || cfg[RASP_CFG_XON]) || cts_s2;
  always_ff @(posedge mclk) begin
    // Restart per delay, else the first ms of a delay is short
    if (reset || state == RASP_IDLE || state == RASP_SEND ||
        state == RASP_WAIT)
      ms_cnt <= 16'h0000;
    else
      ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    tx_start <= 1'b0;
    sent_evt <= 1'b0;
    if (reset) begin
      state <= RASP_IDLE;
      request_to_send_out <= 1'b0;
      ms_left <= 16'h0000;
    end else begin
      case (state)
        RASP_IDLE:
          if (tx_pend && cfg[RASP_CFG_EN]) begin
            request_to_send_out <= 1'b1; // RL3 RL11
            ms_left <= rts_on_ms;
            state <= RASP_RTSON;
          end
        RASP_RTSON:
          if (ms_left == 16'h0000) begin
            state <= RASP_SEND; // RL3
          end else if (ms_tick) begin
            ms_left <= ms_left - 16'h0001;
          end
        RASP_SEND:
          if (!xoff_seen && cts_ok) begin // RL10 RL11
            tx_start <= 1'b1;
            state <= RASP_WAIT;
          end
        RASP_WAIT:
          if (tx_done) begin
            sent_evt <= 1'b1;
            if (tx_pend) begin
              state <= RASP_SEND;
            end else begin
              ms_left <= rts_off_ms;
              state <= RASP_RTSOFF;
            end
          end
        RASP_RTSOFF:
          if (tx_pend) begin
            state <= RASP_SEND;
          end else if (ms_left == 16'h0000) begin
            request_to_send_out <= 1'b0; // RL4
            state <= RASP_IDLE;
          end else if (ms_tick) begin
            ms_left <= ms_left - 16'h0001;
          end
        default: state <= RASP_IDLE;
      endcase
    end
  end
  // Holding register: taken when the sender starts
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_pend <= 1'b0;
      tx_hold <= 8'h00;
    end else if (acc && wr_en && paddr == RASP_TXD_OFS && !tx_pend) begin
      tx_pend <= 1'b1; // RL1
      tx_hold <= pwdata[7:0];
    end else if (tx_start) begin
      tx_pend <= 1'b0;
    end
  end
  rasp_tx u_tx (
    .mclk(mclk),
    .reset(reset),
    .div(div),
    .db8(db8),
    .stop2(stop2),
    .par(par),
    .start(tx_start),
    .data(tx_hold),
    .busy(tx_busy),
    .done(tx_done),
    .txd(tx_line)
  );
  always_ff @(posedge mclk) begin
    if (reset)
      serial_transmit_out <= 1'b1;
    else
      serial_transmit_out <= tx_line; // RL14
  end
  // ==========================================================
  // Receive; 2-wire RS-485 hears its own echo, so mute it
  logic rx_en;
  logic rx_valid, rx_perr, rx_ferr;
  logic [7:0] rx_data;
  assign rx_en = !print_only && // RL13
    !(echo == RASP_ECHO_2W && (tx_busy || state == RASP_WAIT)); // RL9
  rasp_rx u_rx (
    .mclk(mclk),
    .reset(reset),
    .div(div),
    .db8(db8),
    .par(par),
    .rxd(rx_s2),
    .enable(rx_en),
    .valid(rx_valid),
    .data(rx_data),
    .perr(rx_perr),
    .ferr(rx_ferr)
  );
  always_ff @(posedge mclk) begin
    if (reset) begin
      xoff_seen <= 1'b0;
      rx_hold <= 8'h00;
    end else if (rx_valid) begin
      if (cfg[RASP_CFG_XON] && rx_data == RASP_XOFF)
        xoff_seen <= 1'b1; // RL10
      else if (cfg[RASP_CFG_XON] && rx_data == RASP_XON)
        xoff_seen <= 1'b0; // RL10
      else
        rx_hold <= rx_data;
    end else if (!cfg[RASP_CFG_XON]) begin
      xoff_seen <= 1'b0;
    end
  end
  // ==========================================================
  // Response timeout, restarted by each sent character except in print-only mode
  logic tmo_run;
  logic [15:0] tmo_left;
  logic tmo_evt;
  logic [15:0] free_cnt;
  logic ms_tick_free;
  always_ff @(posedge mclk) begin
    tmo_evt <= 1'b0;
    if (reset) begin
      tmo_run <= 1'b0;
      tmo_left <= 16'h0000;
    end else if (sent_evt && !print_only) begin
      tmo_run <= 1'b1; // RL2
      tmo_left <= tmo_ms;
    end else if (rx_valid) begin
      tmo_run <= 1'b0;
    end else if (tmo_run && state != RASP_WAIT) begin
      if (tmo_left == 16'h0000) begin
        tmo_run <= 1'b0;
        tmo_evt <= 1'b1; // RL2
      end else if (ms_tick_free) begin
        tmo_left <= tmo_left - 16'h0001;
      end
    end
  end
  // Restarted by each send so the timeout is whole milliseconds
  always_ff @(posedge mclk) begin
    if (reset || sent_evt || free_cnt == 16'(RASP_MS_CYC - 1))
      free_cnt <= 16'h0000;
    else
      free_cnt <= free_cnt + 16'h0001;
  end
  assign ms_tick_free = free_cnt == 16'(RASP_MS_CYC - 1);
  // ==========================================================
  // Sticky status, set wins over clear
  logic [RASP_NSTAT-1:0] ev, clr;
  logic rx_ovr;
  assign rx_ovr = rx_valid && stat[RASP_ST_RXRDY];
  always_comb begin
    ev = '0;
    ev[RASP_ST_RXRDY] = rx_valid;
    ev[RASP_ST_TXDONE] = sent_evt;
    ev[RASP_ST_PERR] = rx_valid && rx_perr; // RL8
    ev[RASP_ST_FERR] = rx_valid && rx_ferr;
    ev[RASP_ST_TMO] = tmo_evt;
    ev[RASP_ST_OVR] = rx_ovr;
    clr = (acc && wr_en && paddr == RASP_ICLR_OFS) ?
      pwdata[RASP_NSTAT-1:0] : '0;
  end
  always_ff @(posedge mclk) begin
    if (reset)
      stat <= '0;
    else
      stat <= (stat & ~clr) | ev;
  end
  always_ff @(posedge mclk) begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(((stat & ~clr) | ev) & ien);
  end
  // ==========================================================
  // Checks
  property p_rts_first;
    @(posedge mclk) disable iff (reset)
      $rose(tx_start) |-> request_to_send_out;
  endproperty
  a_rts_first: assert property (p_rts_first) // RL3
    else $error("character started with RTS low");
  property p_rts_hold;
    @(posedge mclk) disable iff (reset)
      $fell(request_to_send_out) |-> !tx_busy && !$past(tx_pend);
  endproperty
  a_rts_hold: assert property (p_rts_hold) // RL4
    else $error("RTS dropped while sending");
  property p_xoff;
    @(posedge mclk) disable iff (reset)
      $past(xoff_seen) |-> !tx_start;
  endproperty
  a_xoff: assert property (p_xoff) // RL10
    else $error("sent while paused by XOFF");
  property p_start_bit;
    @(posedge mclk) disable iff (reset)
      tx_start |=> ##1 !serial_transmit_out;
  endproperty
  a_start_bit: assert property (p_start_bit) // RL14
    else $error("missing start bit");
  property p_print;
    @(posedge mclk) disable iff (reset)
      print_only |-> !rx_en;
  endproperty
  a_print: assert property (p_print) // RL13
    else $error("receiver active in print-only mode");
  property p_cts;
    @(posedge mclk) disable iff (reset)
      tx_start && cfg[RASP_CFG_RTSFC] |-> $past(cts_s2);
  endproperty
  a_cts: assert property (p_cts) // RL11
    else $error("sent without clear to send");
  property p_tmo;
    @(posedge mclk) disable iff (reset)
      tmo_evt |=> stat[RASP_ST_TMO];
  endproperty
  a_tmo: assert property (p_tmo) // RL2
    else $error("timeout not flagged");
  property p_echo;
    @(posedge mclk) disable iff (reset)
      echo == RASP_ECHO_2W && tx_busy |-> !rx_en;
  endproperty
  a_echo: assert property (p_echo) // RL9
    else $error("own echo not muted");
endmodule // rasp_top
`default_nettype wire

/* rasp_pkg.sv */
package rasp_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] RASP_CFG_OFS = 8'h00;
  localparam logic [7:0] RASP_TMO_OFS = 8'h04;
  localparam logic [7:0] RASP_RTS_OFS = 8'h08;
  localparam logic [7:0] RASP_TXD_OFS = 8'h0c;
  localparam logic [7:0] RASP_RXD_OFS = 8'h10;
  localparam logic [7:0] RASP_STAT_OFS = 8'h14;
  localparam logic [7:0] RASP_IEN_OFS = 8'h18;
  localparam logic [7:0] RASP_ICLR_OFS = 8'h1c;
  localparam logic [7:0] RASP_BASE_OFS = 8'h20;
  // ==========================================================
  // Config field positions
  localparam int RASP_CFG_BAUD = 0;
  localparam int RASP_CFG_DB8 = 3;
  localparam int RASP_CFG_STOP2 = 4;
  localparam int RASP_CFG_PAR = 5;
  localparam int RASP_CFG_ECHO = 7;
  localparam int RASP_CFG_XON = 9;
  localparam int RASP_CFG_RTSFC = 10;
  localparam int RASP_CFG_PRINT = 11;
  localparam int RASP_CFG_EN = 12;
  // Reset: 19200, 8 bits, 1 stop, odd parity, 4-wire, enabled
  localparam logic [12:0] RASP_CFG_RST = 13'h104e;
  // Status bits
  localparam int RASP_ST_RXRDY = 0;
  localparam int RASP_ST_TXDONE = 1;
  localparam int RASP_ST_PERR = 2;
  localparam int RASP_ST_FERR = 3;
  localparam int RASP_ST_TMO = 4;
  localparam int RASP_ST_OVR = 5;
  localparam int RASP_NSTAT = 6;
  // ==========================================================
  // Timing
  localparam int RASP_CLK_HZ = 10000000;
  localparam int RASP_TMO_MS = 800;
  localparam int RASP_MS_CYC = RASP_CLK_HZ / 1000;
  localparam logic [15:0] RASP_TMO_RST = 16'(RASP_TMO_MS);
  localparam logic [15:0] RASP_RTSD_RST = 16'h0000;
  localparam logic [15:0] RASP_BASE_RST = 16'h1000;
  localparam logic [7:0] RASP_XON = 8'h11;
  localparam logic [7:0] RASP_XOFF = 8'h13;
  // Parity and echo encodings
  typedef enum logic [1:0] {
    RASP_PAR_NONE = 2'b00,
    RASP_PAR_EVEN = 2'b01,
    RASP_PAR_ODD = 2'b10
  } rasp_par_t;
  typedef enum logic [1:0] {
    RASP_ECHO_4W = 2'b00,
    RASP_ECHO_232 = 2'b01,
    RASP_ECHO_2W = 2'b10
  } rasp_echo_t;
  // Baud divisors, clocks per bit at 10 MHz
  function automatic logic [15:0] rasp_div(input logic [2:0] sel);
    case (sel)
      3'h0: rasp_div = 16'(RASP_CLK_HZ / 300);
      3'h1: rasp_div = 16'(RASP_CLK_HZ / 600);
      3'h2: rasp_div = 16'(RASP_CLK_HZ / 900);
      3'h3: rasp_div = 16'(RASP_CLK_HZ / 2400);
      3'h4: rasp_div = 16'(RASP_CLK_HZ / 4800);
      3'h5: rasp_div = 16'(RASP_CLK_HZ / 9600);
      3'h6: rasp_div = 16'(RASP_CLK_HZ / 19200);
      default: rasp_div = 16'(RASP_CLK_HZ / 38400);
    endcase
  endfunction
endpackage

/* rasp_tx.sv */
`timescale 1ns/10ps
`default_nettype none
module rasp_tx
  import rasp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Frame format
  input wire logic [15:0] div,
  input wire logic db8,
  input wire logic stop2,
  input wire logic [1:0] par,
  // Character
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic done,
  // Line
  output logic txd
);
  import rasp_pkg::*;
  // ==========================================================
  // Shift register of data, parity and stops (start bit driven directly), LSB first
  logic [11:0] shreg;
  logic [3:0] left;
  logic [15:0] cnt;
  logic [7:0] d;
  logic pbit;
  logic haspar;
  always_comb begin
    d = db8 ? data : {1'b0, data[6:0]};
    haspar = par != RASP_PAR_NONE;
    pbit = (^d) ^ (par == RASP_PAR_ODD);
  end
  always_ff @(posedge mclk) begin
    done <= 1'b0;
    if (reset) begin
      busy <= 1'b0;
      txd <= 1'b1;
      shreg <= 12'hfff;
      left <= 4'h0;
      cnt <= 16'h0000;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        txd <= 1'b0;
        cnt <= div - 16'h0001;
        // Data, parity, stops after the start bit
        if (db8)
          shreg <= haspar ? {2'b11, 1'b1, pbit, d} : {3'b111, 1'b1, d};
        else
          shreg <= haspar ? {3'b111, 1'b1, pbit, d[6:0]}
                          : {4'b1111, 1'b1, d[6:0]};
        left <= 4'(7 + 32'(db8) + 32'(haspar) + 1 + 32'(stop2));
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else if (left == 4'h0) begin
      busy <= 1'b0;
      done <= 1'b1;
      txd <= 1'b1;
    end else begin
      txd <= shreg[0];
      shreg <= {1'b1, shreg[11:1]};
      left <= left - 4'h1;
      cnt <= div - 16'h0001;
    end
  end
endmodule // rasp_tx
`default_nettype wire

/* rasp_rx.sv */
`timescale 1ns/10ps
`default_nettype none
module rasp_rx
  import rasp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Frame format
  input wire logic [15:0] div,
  input wire logic db8,
  input wire logic [1:0] par,
  // Line, already synchronised
  input wire logic rxd,
  input wire logic enable,
  // Result
  output logic valid,
  output logic [7:0] data,
  output logic perr,
  output logic ferr
);
  import rasp_pkg::*;
  // ==========================================================
  logic busy;
  logic [15:0] cnt;
  logic [3:0] idx;
  logic [8:0] sh;
  logic [3:0] nbits;
  logic haspar;
  always_comb begin
    haspar = par != RASP_PAR_NONE;
    nbits = 4'(7 + 32'(db8) + 32'(haspar));
  end
  always_ff @(posedge mclk) begin
    valid <= 1'b0;
    if (reset) begin
      busy <= 1'b0;
      cnt <= 16'h0000;
      idx <= 4'h0;
      sh <= 9'h000;
      data <= 8'h00;
      perr <= 1'b0;
      ferr <= 1'b0;
    end else if (!busy) begin
      // Sample mid start bit
      if (enable && !rxd) begin
        busy <= 1'b1;
        cnt <= {1'b0, div[15:1]};
        idx <= 4'h0;
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else begin
      cnt <= div - 16'h0001;
      if (idx == 4'h0 && rxd) begin
        busy <= 1'b0;
      end else if (idx == nbits + 4'h1) begin
        // Stop bit: second stop bit not demanded on receive
        busy <= 1'b0;
        valid <= 1'b1;
        ferr <= !rxd;
        if (db8) begin
          data <= sh[7:0];
          perr <= haspar && ((^sh) != (par == RASP_PAR_ODD));
        end else begin
          data <= {1'b0, sh[6:0]};
          perr <= haspar && ((^sh[7:0]) != (par == RASP_PAR_ODD));
        end
        idx <= 4'h0;
      end else begin
        if (idx != 4'h0)
          sh[idx - 4'h1] <= rxd;
        idx <= idx + 4'h1;
      end
    end
  end
endmodule // rasp_rx
`default_nettype wire

/* rasp_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Far-side serial device: terminal or printer
module rasp_partner (
  // Clock
  input wire logic mclk,
  // Lines
  input wire logic txd,
  output logic rxd,
  output logic cts
);
  // Idle line is the mark level, so high is its true resting value
  initial begin
    rxd = 1'b1;
    cts = 1'b1;
  end

  task automatic bit_out(input logic b, input int div);
    rxd <= b;
    repeat (div) @(posedge mclk);
  endtask

  // ==========================================================
  // Send one frame, optionally with a wrong parity bit
  task automatic send_char(input int div, input int nb, input int par,
      input logic [7:0] d, input logic bad);
    logic [7:0] m;
    logic p;
    m = (8'h01 << nb) - 8'h01;
    p = (^(d & m)) ^ (par == 2) ^ bad;
    @(posedge mclk);
    bit_out(1'b0, div);
    for (int i = 0; i < nb; i++) bit_out(d[i], div);
    if (par != 0) bit_out(p, div);
    bit_out(1'b1, 2 * div);
  endtask

  // ==========================================================
  // Take one frame, sampling each bit in its middle
  task automatic get_char(input int div, input int nb, input int par,
      input int ns, output logic [7:0] d, output logic p, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    repeat (div / 2) @(posedge mclk);
    ok = (txd === 1'b0);
    d = 8'h00;
    for (int i = 0; i < nb; i++) begin
      repeat (div) @(posedge mclk);
      d[i] = txd;
    end
    p = 1'b0;
    if (par != 0) begin
      repeat (div) @(posedge mclk);
      p = txd;
    end
    for (int s = 0; s < ns; s++) begin
      repeat (div) @(posedge mclk);
      ok = ok & (txd === 1'b1);
    end
  endtask
endmodule // rasp_partner
`default_nettype wire

/* test_raw_ascii_serial_port.sv */
`timescale 1ns/10ps
`default_nettype none
module test_raw_ascii_serial_port;
  import rasp_pkg::*;
  localparam int bit_div = RASP_CLK_HZ / 38400;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic txd_w, rxd_w, rts_w, cts_w;
  int miscompares, n_checks;

  rasp_top rasp_top_inst (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_transmit_out(txd_w), .serial_receive_in(rxd_w),
    .request_to_send_out(rts_w), .clear_to_send_in(cts_w), .irq(irq));
  rasp_partner rasp_partner_inst (.mclk(mclk), .txd(txd_w), .rxd(rxd_w),
    .cts(cts_w));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Idle cycle first, so a release never meets a new setup in one step
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50)
      check(32'(pready), 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wait_cycles(input logic lvl, ref logic s, output int n);
    n = 0;
    while (s !== lvl && n < 20000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(RASP_CFG_OFS, q);
    check(q, 32'(RASP_CFG_RST));
    rd(RASP_TMO_OFS, q);
    check(q, 32'd800);
    rd(RASP_RTS_OFS, q);
    check(q, 32'h0);
    rd(RASP_BASE_OFS, q);
    check(q, 32'(RASP_BASE_RST));
    wr(RASP_BASE_OFS, 32'h0000_3000);
    rd(RASP_BASE_OFS, q);
    check(q, 32'h0000_3000);
    apb(1'b0, 8'h24, 32'h0, q, e);
    check(32'(e), 32'h1);
    $display("test regs done");
  endtask

  task automatic t_tx;
    logic [31:0] q;
    logic [7:0] d;
    logic p, ok;
    int n;
    wr(RASP_CFG_OFS, 32'h0000_103f);
    wr(RASP_RTS_OFS, 32'h0001_0001);
    wr(RASP_TXD_OFS, 32'h0000_00a5);
    wait_cycles(1'b1, rts_w, n);
    check(32'(n < 20), 32'h1);
    wait_cycles(1'b0, txd_w, n);
    check(32'(n >= RASP_MS_CYC - 10 && n <= RASP_MS_CYC + 300), 1);
    rasp_partner_inst.get_char(bit_div, 8, 1, 2, d, p, ok);
    check(32'(d), 32'ha5);
    check(32'(p), 32'(^8'ha5));
    check(32'(ok), 32'h1);
    wait_cycles(1'b0, rts_w, n);
    check(32'(n >= RASP_MS_CYC && n <= RASP_MS_CYC + 400), 1);
    rd(RASP_STAT_OFS, q);
    check(32'(q[RASP_ST_TXDONE]), 32'h1);
    $display("test tx done");
  endtask

  task automatic t_rx;
    logic [31:0] q;
    wr(RASP_ICLR_OFS, 32'h3f);
    wr(RASP_CFG_OFS, 32'h0000_1047);
    wr(RASP_IEN_OFS, 32'h0);
    rasp_partner_inst.send_char(bit_div, 7, 2, 8'h5a, 1'b0);
    rd(RASP_STAT_OFS, q);
    check(32'(q[RASP_ST_RXRDY]), 32'h1);
    check(32'(q[RASP_ST_PERR]), 32'h0);
    check(32'(irq), 32'h0);
    wr(RASP_IEN_OFS, 32'h1);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'h1);
    rd(RASP_RXD_OFS, q);
    check(q & 32'h7f, 32'h5a);
    wr(RASP_ICLR_OFS, 32'h3f);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'h0);
    rasp_partner_inst.send_char(bit_div, 7, 2, 8'h33, 1'b1);
    rd(RASP_STAT_OFS, q);
    check(32'(q[RASP_ST_PERR]), 32'h1);
    wr(RASP_ICLR_OFS, 32'h3f);
    $display("test rx done");
  endtask

  task automatic t_tmo;
    logic [31:0] q;
    logic [7:0] d;
    logic p, ok;
    realtime t0;
    int n;
    wr(RASP_CFG_OFS, 32'h0000_100f);
    wr(RASP_RTS_OFS, 32'h0);
    wr(RASP_TMO_OFS, 32'h1);
    wr(RASP_TXD_OFS, 32'h41);
    rasp_partner_inst.get_char(bit_div, 8, 0, 1, d, p, ok);
    t0 = $realtime;
    check(32'(d), 32'h41);
    rd(RASP_STAT_OFS, q);
    check(32'(q[RASP_ST_TMO]), 32'h0);
    n = 0;
    while (q[RASP_ST_TMO] !== 1'b1 && n < 6000) begin
      rd(RASP_STAT_OFS, q);
      n++;
    end
    check(32'(q[RASP_ST_TMO]), 32'h1);
    n = int'(($realtime - t0) / 100.0);
    check(32'(n >= RASP_MS_CYC - 500 && n <= RASP_MS_CYC + 500), 1);
    $display("test timeout done");
  endtask

  task automatic t_flow;
    logic [31:0] q;
    logic [7:0] d;
    logic p, ok;
    wr(RASP_ICLR_OFS, 32'h3f);
    wr(RASP_CFG_OFS, 32'h0000_120f);
    rasp_partner_inst.send_char(bit_div, 8, 0, RASP_XOFF, 1'b0);
    wr(RASP_TXD_OFS, 32'h52);
    repeat (3000) @(posedge mclk);
    check(32'(txd_w), 32'h1);
    fork
      rasp_partner_inst.send_char(bit_div, 8, 0, RASP_XON, 1'b0);
      rasp_partner_inst.get_char(bit_div, 8, 0, 1, d, p, ok);
    join
    check(32'(d), 32'h52);
    check(32'(ok), 32'h1);
    wr(RASP_ICLR_OFS, 32'h3f);
    wr(RASP_CFG_OFS, 32'h0000_180f);
    rasp_partner_inst.send_char(bit_div, 8, 0, 8'h61, 1'b0);
    rd(RASP_STAT_OFS, q);
    check(32'(q[RASP_ST_RXRDY]), 32'h0);
    rd(RASP_RXD_OFS, q);
    check(q, 32'h33);
    $display("test flow done");
  endtask

  // ==========================================================
  // Verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run is near 55k cycles; far beyond that means a hang
  initial begin
    #10000000;
    miscompares++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_tmo();
    t_flow();
    summarize();
  end
endmodule // test_raw_ascii_serial_port
`default_nettype wire
